//--- common/tlsl_regs.vh
// Constants for the torque limit select block: register offsets,
// field positions, reset values and function codes.
// Assumes a 32-bit Avalon-MM slave with word-aligned byte addresses.
`ifndef TLSL_REGS_VH
`define TLSL_REGS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define TLSL_OFS_CTRL 8'h00
`define TLSL_OFS_LIMITS 8'h04
`define TLSL_OFS_IN_ASG_LO 8'h08
`define TLSL_OFS_IN_ASG_HI 8'h0C
`define TLSL_OFS_OUT_ASG_LO 8'h10
`define TLSL_OFS_OUT_ASG_HI 8'h14
`define TLSL_OFS_METER 8'h18
`define TLSL_OFS_STATUS 8'h1C
`define TLSL_OFS_VIEW 8'h20

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define TLSL_CTRL_CURVE_LSB 0
`define TLSL_CTRL_CURVE_MSB 7
`define TLSL_CTRL_MODE_LSB 8
`define TLSL_CTRL_MODE_MSB 10
`define TLSL_CTRL_RESTART_LSB 12
`define TLSL_CTRL_RESTART_MSB 13
`define TLSL_ST_FLAG 12
`define TLSL_ST_ACTIVE 13
`define TLSL_ST_RUN_OK 14
`define TLSL_ST_FREE_RUN 15
`define TLSL_ST_MON_VALID 16
`define TLSL_ST_GATE 17
`define TLSL_ST_MODE_OK 18

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define TLSL_RST_CTRL 32'h0000_0003
`define TLSL_RST_LIMITS 32'hB4B4_B4B4
`define TLSL_RST_ASG 32'h0000_0000
`define TLSL_RST_METER 32'h0000_0000

// ----------------------------------------------------------------
// Codes
// ----------------------------------------------------------------
`define TLSL_CURVE_SLV 8'h03
`define TLSL_CURVE_SLV0 8'h04
`define TLSL_CURVE_VEC 8'h05
`define TLSL_MODE_QUAD 3'h0
`define TLSL_MODE_SWITCH 3'h1
`define TLSL_MODE_ANALOG 3'h2
`define TLSL_MODE_OPT1 3'h3
`define TLSL_MODE_OPT2 3'h4
`define TLSL_IN_GATE 8'h28
`define TLSL_IN_SW1 8'h29
`define TLSL_IN_SW2 8'h2A
`define TLSL_IN_FLUX 8'h37
`define TLSL_OUT_LIMITED 8'h0A
`define TLSL_MTR_TORQUE 8'h02
`define TLSL_MTR_SIGNED 8'h0B

// Limits are in tenths of a percent; maximum current torque is 200%
`define TLSL_MAX_TORQUE 12'h7D0
`define TLSL_PCT_SCALE 12'h00A
`define TLSL_ANALOG_SPAN 22'h00_07D0

`endif

//--- rtl/tlsl_limit_mux.v
// Limit source selector for the torque limit select block.
// Pure combinational; the parent registers the result.
`timescale 1ns/1ps
`include "tlsl_regs.vh"

module tlsl_limit_mux #(
  parameter ADC_BITS = 10
) (
  // Selection
  input wire [2:0] i_mode,
  input wire i_rev,
  input wire i_regen,
  input wire i_sw1,
  input wire i_sw2,
  // Sources, tenths of a percent except the raw analog code
  input wire [47:0] i_limits,
  input wire [ADC_BITS-1:0] i_analog,
  input wire [11:0] i_opt1,
  input wire [11:0] i_opt2,
  input wire i_opt_present,
  // Result
  output reg [11:0] o_limit,
  output reg o_mode_ok
);

  localparam [21:0] ADC_MAX = {{(22-ADC_BITS){1'b0}}, {ADC_BITS{1'b1}}};

  reg [1:0] quad_idx;
  reg [21:0] analog_prod;
  reg [21:0] analog_tenths;

  always @* begin
    // Forward power, reverse regen, reverse power, forward regen
    case ({i_rev, i_regen})
      2'h0: quad_idx = 2'h0;
      2'h3: quad_idx = 2'h1;
      2'h2: quad_idx = 2'h2;
      default: quad_idx = 2'h3;
    endcase
    // 0..full-scale code maps linearly onto 0..200%
    analog_prod = {{(22-ADC_BITS){1'b0}}, i_analog} * `TLSL_ANALOG_SPAN;
    analog_tenths = analog_prod / ADC_MAX;
    o_mode_ok = 1'b1;
    case (i_mode)
      `TLSL_MODE_QUAD: begin
        o_limit = i_limits[quad_idx*12 +: 12];
      end
      `TLSL_MODE_SWITCH: begin
        o_limit = i_limits[{i_sw2, i_sw1}*12 +: 12];
      end
      `TLSL_MODE_ANALOG: begin
        o_limit = analog_tenths[11:0];
      end
      `TLSL_MODE_OPT1: begin
        o_limit = i_opt_present ? i_opt1 : `TLSL_MAX_TORQUE;
        o_mode_ok = i_opt_present;
      end
      `TLSL_MODE_OPT2: begin
        o_limit = i_opt_present ? i_opt2 : `TLSL_MAX_TORQUE;
        o_mode_ok = i_opt_present;
      end
      default: begin
        o_limit = `TLSL_MAX_TORQUE;
        o_mode_ok = 1'b0;
      end
    endcase
  end

endmodule

//--- rtl/tlsl_top.v
// Torque limit selection, limit gating, flux forcing and torque meter
// sourcing, with an Avalon-MM register slave.
// Assumes torque estimate, demand, run command and option board words
// come from logic on i_clk; terminal pins and the board-present pin
// are asynchronous and are synchronised here.
//
// Our own choices: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "tlsl_regs.vh"

module tlsl_top #(
  parameter ADC_BITS = 10,
  parameter N_IN = 8,
  parameter N_OUT = 5,
  parameter [15:0] RATED_GAIN = 16'h0100
) (
  // Clock and reset
  input wire i_clk,
  input wire i_rst_n,
  // Avalon-MM slave
  input wire [7:0] i_avs_address,
  input wire i_avs_read,
  input wire i_avs_write,
  input wire [31:0] i_avs_writedata,
  input wire [3:0] i_avs_byteenable,
  output reg [31:0] o_avs_readdata,
  output reg o_avs_waitrequest,
  // Terminals and option board pins
  input wire [N_IN-1:0] i_term_in,
  input wire i_opt_present,
  // Drive state, same clock
  input wire [ADC_BITS-1:0] i_aux_analog_input,
  input wire [11:0] i_opt1_limit,
  input wire [11:0] i_opt2_limit,
  input wire i_rev,
  input wire i_regen,
  input wire i_run_cmd,
  input wire i_motor_running,
  input wire [11:0] i_torque_demand,
  input wire signed [15:0] i_torque_est,
  // Limit outputs
  output reg [11:0] o_torque_limit,
  output reg o_limit_active,
  output reg [N_OUT-1:0] o_term_out,
  // Run and flux outputs
  output reg o_run_accept,
  output reg o_flux_prebuild,
  output reg o_free_run,
  output reg o_restart_req,
  output reg [1:0] o_restart_mode,
  // Meter outputs
  output reg [15:0] o_pulse_meter_val,
  output reg signed [15:0] o_voltage_meter_val,
  output reg [15:0] o_current_meter_val,
  output reg o_monitor_valid
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg [31:0] ctrl;
  reg [31:0] limits;
  reg [31:0] in_asg_lo;
  reg [31:0] in_asg_hi;
  reg [31:0] out_asg_lo;
  reg [31:0] out_asg_hi;
  reg [31:0] meter;
  reg [N_IN-1:0] term_meta;
  reg [N_IN-1:0] term_sync;
  reg opt_meta;
  reg opt_sync;
  reg flux_prev;
  reg limited_flag;
  reg signed [15:0] torque_view;

  wire [7:0] curve = ctrl[`TLSL_CTRL_CURVE_MSB:`TLSL_CTRL_CURVE_LSB];
  wire [2:0] mode = ctrl[`TLSL_CTRL_MODE_MSB:`TLSL_CTRL_MODE_LSB];
  wire [63:0] in_asg = {in_asg_hi, in_asg_lo};
  wire [63:0] out_asg = {out_asg_hi, out_asg_lo};
  wire vector_mode = (curve == `TLSL_CURVE_SLV) || (curve == `TLSL_CURVE_SLV0) ||
                     (curve == `TLSL_CURVE_VEC);

  // ----------------------------------------------------------------
  // Input terminal function decode
  // ----------------------------------------------------------------
  wire [N_IN-1:0] is_gate;
  wire [N_IN-1:0] is_sw1;
  wire [N_IN-1:0] is_sw2;
  wire [N_IN-1:0] is_flux;
  genvar gi;
  generate
    for (gi = 0; gi < N_IN; gi = gi + 1) begin : g_in
      assign is_gate[gi] = in_asg[gi*8 +: 8] == `TLSL_IN_GATE;
      assign is_sw1[gi] = in_asg[gi*8 +: 8] == `TLSL_IN_SW1;
      assign is_sw2[gi] = in_asg[gi*8 +: 8] == `TLSL_IN_SW2;
      assign is_flux[gi] = in_asg[gi*8 +: 8] == `TLSL_IN_FLUX;
    end
  endgenerate

  // An unassigned switch reads as off; several terminals on one function OR
  wire sw1_on = |(is_sw1 & term_sync);
  wire sw2_on = |(is_sw2 & term_sync);
  wire gate_assigned = |is_gate;
  wire gate_on = ~gate_assigned | |(is_gate & term_sync);
  wire flux_assigned = |is_flux;
  wire flux_on = |(is_flux & term_sync);

  // ----------------------------------------------------------------
  // Limit selection
  // ----------------------------------------------------------------
  wire [47:0] lim_tenths;
  genvar gl;
  generate
    for (gl = 0; gl < 4; gl = gl + 1) begin : g_lim
      wire [11:0] raw = {4'h0, limits[gl*8 +: 8]} * `TLSL_PCT_SCALE;
      // Clamp keeps a bad byte from exceeding maximum-current torque
      assign lim_tenths[gl*12 +: 12] = (raw > `TLSL_MAX_TORQUE) ?
                                       `TLSL_MAX_TORQUE : raw;
    end
  endgenerate

  wire [11:0] sel_limit;
  wire mode_ok;
  tlsl_limit_mux #(
    .ADC_BITS(ADC_BITS)
  ) u_mux (
    .i_mode(mode),
    .i_rev(i_rev),
    .i_regen(i_regen),
    .i_sw1(sw1_on),
    .i_sw2(sw2_on),
    .i_limits(lim_tenths),
    .i_analog(i_aux_analog_input),
    .i_opt1(i_opt1_limit),
    .i_opt2(i_opt2_limit),
    .i_opt_present(opt_sync),
    .o_limit(sel_limit),
    .o_mode_ok(mode_ok)
  );

  // ----------------------------------------------------------------
  // Limit gating
  // ----------------------------------------------------------------
  // Option board words are not range checked upstream; cap them like the stored limits
  wire [11:0] sel_capped = (sel_limit > `TLSL_MAX_TORQUE) ? `TLSL_MAX_TORQUE :
                           sel_limit;
  wire limiting = vector_mode & gate_on & mode_ok;
  wire [11:0] next_limit = limiting ? sel_capped : `TLSL_MAX_TORQUE;
  wire next_flag = limiting & (i_torque_demand >= next_limit);

  // ----------------------------------------------------------------
  // Flux forcing
  // ----------------------------------------------------------------
  // Outside vector curves the flux terminal has no effect at all
  wire flux_gating = flux_assigned & vector_mode;
  wire next_run_accept = i_run_cmd & (~flux_gating | flux_on);
  wire flux_fall = flux_gating & flux_prev & ~flux_on;
  wire flux_rise = flux_gating & ~flux_prev & flux_on;

  // ----------------------------------------------------------------
  // Torque monitor
  // ----------------------------------------------------------------
  wire signed [31:0] view_prod = i_torque_est * $signed({1'b0, RATED_GAIN});
  // A gain above unity can overflow the view; saturate instead of wrapping sign
  wire view_ovf = view_prod[31:23] != {9{view_prod[31]}};
  wire signed [15:0] next_view = view_ovf ? (view_prod[31] ? 16'h8001 : 16'h7FFF) :
                                 view_prod[23:8];
  wire [15:0] view_mag = torque_view[15] ? (16'h0000 - torque_view) : torque_view;

  // ----------------------------------------------------------------
  // Avalon-MM slave
  // ----------------------------------------------------------------
  // One wait state: the request is decoded and the answer held ready
  // before waitrequest drops, so read data stand at the completing edge.
  wire req = i_avs_read | i_avs_write;
  wire done = req & ~o_avs_waitrequest;
  wire wr_go = i_avs_write & done;
  wire [31:0] wmask = {{8{i_avs_byteenable[3]}}, {8{i_avs_byteenable[2]}},
                       {8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};
  wire [31:0] status = {13'h0000, mode_ok, gate_on, o_monitor_valid, o_free_run,
                        o_run_accept, o_limit_active, limited_flag, o_torque_limit};

  reg [31:0] rd_mux;
  always @* begin
    case (i_avs_address)
      `TLSL_OFS_CTRL: rd_mux = ctrl;
      `TLSL_OFS_LIMITS: rd_mux = limits;
      `TLSL_OFS_IN_ASG_LO: rd_mux = in_asg_lo;
      `TLSL_OFS_IN_ASG_HI: rd_mux = in_asg_hi;
      `TLSL_OFS_OUT_ASG_LO: rd_mux = out_asg_lo;
      `TLSL_OFS_OUT_ASG_HI: rd_mux = out_asg_hi;
      `TLSL_OFS_METER: rd_mux = meter;
      `TLSL_OFS_STATUS: rd_mux = status;
      `TLSL_OFS_VIEW: rd_mux = {16'h0000, torque_view};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata <= 32'h0000_0000;
    end else begin
      o_avs_waitrequest <= ~(req & o_avs_waitrequest);
      if (i_avs_read & o_avs_waitrequest) begin
        o_avs_readdata <= rd_mux;
      end
    end
  end

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      ctrl <= `TLSL_RST_CTRL;
      limits <= `TLSL_RST_LIMITS;
      in_asg_lo <= `TLSL_RST_ASG;
      in_asg_hi <= `TLSL_RST_ASG;
      out_asg_lo <= `TLSL_RST_ASG;
      out_asg_hi <= `TLSL_RST_ASG;
      meter <= `TLSL_RST_METER;
    end else if (wr_go) begin
      case (i_avs_address)
        `TLSL_OFS_CTRL: begin
          ctrl <= (ctrl & ~wmask) | (i_avs_writedata & wmask & 32'h0000_37FF);
        end
        `TLSL_OFS_LIMITS: begin
          limits <= (limits & ~wmask) | (i_avs_writedata & wmask);
        end
        `TLSL_OFS_IN_ASG_LO: begin
          in_asg_lo <= (in_asg_lo & ~wmask) | (i_avs_writedata & wmask);
        end
        `TLSL_OFS_IN_ASG_HI: begin
          in_asg_hi <= (in_asg_hi & ~wmask) | (i_avs_writedata & wmask);
        end
        `TLSL_OFS_OUT_ASG_LO: begin
          out_asg_lo <= (out_asg_lo & ~wmask) | (i_avs_writedata & wmask);
        end
        `TLSL_OFS_OUT_ASG_HI: begin
          out_asg_hi <= (out_asg_hi & ~wmask) | (i_avs_writedata & wmask & 32'h0000_00FF);
        end
        `TLSL_OFS_METER: begin
          meter <= (meter & ~wmask) | (i_avs_writedata & wmask & 32'h00FF_FFFF);
        end
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      term_meta <= {N_IN{1'b0}};
      term_sync <= {N_IN{1'b0}};
      opt_meta <= 1'b0;
      opt_sync <= 1'b0;
    end else begin
      term_meta <= i_term_in;
      term_sync <= term_meta;
      opt_meta <= i_opt_present;
      opt_sync <= opt_meta;
    end
  end

  // ----------------------------------------------------------------
  // Limit and run control
  // ----------------------------------------------------------------
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_torque_limit <= `TLSL_MAX_TORQUE;
      o_limit_active <= 1'b0;
      limited_flag <= 1'b0;
      o_run_accept <= 1'b0;
      o_flux_prebuild <= 1'b0;
      o_free_run <= 1'b0;
      o_restart_req <= 1'b0;
      o_restart_mode <= 2'h0;
      flux_prev <= 1'b0;
    end else begin
      o_torque_limit <= next_limit;
      o_limit_active <= limiting;
      limited_flag <= next_flag;
      o_run_accept <= next_run_accept & ~(o_free_run & ~flux_rise);
      o_flux_prebuild <= flux_gating & flux_on;
      flux_prev <= flux_on;
      o_restart_req <= 1'b0;
      if (flux_fall & i_motor_running) begin
        o_free_run <= 1'b1;
      end else if (flux_rise & o_free_run) begin
        o_free_run <= 1'b0;
        o_restart_req <= 1'b1;
        o_restart_mode <= ctrl[`TLSL_CTRL_RESTART_MSB:`TLSL_CTRL_RESTART_LSB];
      end else if (~flux_gating) begin
        o_free_run <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Output terminals
  // ----------------------------------------------------------------
  // One process owns the whole output vector; the generate only decodes
  wire [N_OUT-1:0] is_flag_out;
  genvar go;
  generate
    for (go = 0; go < N_OUT; go = go + 1) begin : g_out
      assign is_flag_out[go] = out_asg[go*8 +: 8] == `TLSL_OUT_LIMITED;
    end
  endgenerate

  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_term_out <= {N_OUT{1'b0}};
    end else begin
      o_term_out <= is_flag_out & {N_OUT{next_flag}};
    end
  end

  // ----------------------------------------------------------------
  // Torque monitor and meters
  // ----------------------------------------------------------------
  // Meters read zero while the monitor is disabled rather than noise
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      torque_view <= 16'h0000;
      o_monitor_valid <= 1'b0;
      o_pulse_meter_val <= 16'h0000;
      o_voltage_meter_val <= 16'h0000;
      o_current_meter_val <= 16'h0000;
    end else begin
      torque_view <= vector_mode ? next_view : 16'h0000;
      o_monitor_valid <= vector_mode;
      o_pulse_meter_val <= (o_monitor_valid && meter[7:0] == `TLSL_MTR_TORQUE) ?
                           view_mag : 16'h0000;
      o_voltage_meter_val <= (o_monitor_valid && meter[15:8] == `TLSL_MTR_SIGNED) ?
                             torque_view : 16'h0000;
      // Signed code is refused on the current meter; it only shows magnitude
      o_current_meter_val <= (o_monitor_valid && meter[23:16] == `TLSL_MTR_TORQUE) ?
                             view_mag : 16'h0000;
    end
  end

endmodule

//--- test/tlsl_checker_assertions.sv
// Checker for the torque limit select block, bound to its top module.
// Assumes one clock domain and the synchronous active-low reset.
`timescale 1ns/1ps
module tlsl_checker #(
  parameter N_OUT = 5
) (
  // Clock and reset
  input wire i_clk,
  input wire i_rst_n,
  // Bus
  input wire i_avs_read,
  input wire i_avs_write,
  input wire o_avs_waitrequest,
  // Outputs watched
  input wire [11:0] o_torque_limit,
  input wire o_limit_active,
  input wire [N_OUT-1:0] o_term_out,
  input wire o_run_accept,
  input wire o_free_run,
  input wire o_restart_req,
  input wire o_monitor_valid
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  chk_bus_answer: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest
    |=> !o_avs_waitrequest) else $error("bus request not answered next cycle");
  chk_bus_short: assert property ($fell(o_avs_waitrequest) |=> o_avs_waitrequest)
    else $error("waitrequest low longer than one cycle");
  chk_idle_full: assert property (!o_limit_active |-> o_torque_limit == 12'h7D0)
    else $error("limit not at maximum while limiting off");
  chk_limit_cap: assert property (o_torque_limit <= 12'h7D0)
    else $error("limit above maximum current torque");
  chk_active_vector: assert property (o_limit_active |-> o_monitor_valid)
    else $error("limiting outside vector curves");
  chk_flag_active: assert property (|o_term_out |-> o_limit_active)
    else $error("limited flag without limiting");
  chk_run_free: assert property (o_run_accept |-> !o_free_run)
    else $error("run accepted while free-running");
  chk_restart_pulse: assert property (o_restart_req |=> !o_restart_req)
    else $error("restart request longer than one cycle");
  chk_restart_cause: assert property (o_restart_req |-> $past(o_free_run))
    else $error("restart without prior free-run");
endmodule

//--- test/tlsl_pin_model.sv
// Far-side model: input terminal pins and option board presence pin.
// Assumes the bench sets the wanted levels; pins change after an edge.
`timescale 1ns/1ps
module tlsl_pin_model (
  // Clock
  input wire i_clk,
  // Wanted levels
  input wire i_sw1,
  input wire i_sw2,
  input wire i_gate,
  input wire i_flux,
  input wire i_board,
  // Pins
  output reg [7:0] o_term_in,
  output reg o_opt_present
);
  // Terminals 0 to 3 carry switch one, switch two, gate and flux;
  // unwired terminals read off, as an open contact would
  initial o_term_in = 8'h00;
  initial o_opt_present = 1'b0;
  always @(posedge i_clk) begin
    o_term_in <= {4'h0, i_flux, i_gate, i_sw2, i_sw1};
    o_opt_present <= i_board;
  end
endmodule

//--- test/torque_limit_select_logic_bench.sv
// Self-checking bench for the torque limit select block.
// Assumes tlsl_top, tlsl_pin_model and tlsl_checker are compiled first.
`timescale 1ns/1ps
module torque_limit_select_logic_bench;
  reg clk, rst_n, rd_en, wr_en, rev, regen, run_cmd, running;
  reg sw1, sw2, gate, flux, board;
  reg [7:0] addr;
  reg [31:0] wdata, rdata;
  reg [9:0] analog;
  reg [11:0] opt1, opt2, demand;
  reg [15:0] est;
  reg [1:0] quad [0:3];
  integer fails, compares, i, k;
  wire [7:0] term_in;
  wire opt_present, waitreq, active, run_ok, prebuild, free_run, restart, mon_ok;
  wire [31:0] readdata;
  wire [11:0] limit;
  wire [4:0] term_out;
  wire [1:0] rmode;
  wire [15:0] pulse_val, volt_val, curr_val;

  tlsl_pin_model u_tlsl_pin_model (.i_clk(clk), .i_sw1(sw1), .i_sw2(sw2), .i_gate(gate),
    .i_flux(flux), .i_board(board), .o_term_in(term_in), .o_opt_present(opt_present));
  tlsl_top u_tlsl_top (.i_clk(clk), .i_rst_n(rst_n), .i_avs_address(addr),
    .i_avs_read(rd_en), .i_avs_write(wr_en), .i_avs_writedata(wdata),
    .i_avs_byteenable(4'hF), .o_avs_readdata(readdata), .o_avs_waitrequest(waitreq),
    .i_term_in(term_in), .i_opt_present(opt_present), .i_aux_analog_input(analog),
    .i_opt1_limit(opt1), .i_opt2_limit(opt2), .i_rev(rev), .i_regen(regen),
    .i_run_cmd(run_cmd), .i_motor_running(running), .i_torque_demand(demand),
    .i_torque_est(est), .o_torque_limit(limit), .o_limit_active(active),
    .o_term_out(term_out), .o_run_accept(run_ok), .o_flux_prebuild(prebuild),
    .o_free_run(free_run), .o_restart_req(restart), .o_restart_mode(rmode),
    .o_pulse_meter_val(pulse_val), .o_voltage_meter_val(volt_val),
    .o_current_meter_val(curr_val), .o_monitor_valid(mon_ok));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task chk(input [8*8-1:0] name, input [31:0] exp, input [31:0] got);
    begin
      compares = compares + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("wrong value %0s expected %h seen %h", name, exp, got);
      end
    end
  endtask
  // Holds the request until waitrequest is seen low; the watchdog bounds it
  task bus(input w, input [7:0] a, input [31:0] d);
    begin
      addr <= a;
      wdata <= d;
      wr_en <= w;
      rd_en <= !w;
      @(posedge clk);
      while (waitreq !== 1'b0) @(posedge clk);
      rdata = readdata;
      wr_en <= 1'b0;
      rd_en <= 1'b0;
      @(posedge clk);
    end
  endtask
  // Terminal effects need pin register, two sync flops and the output flop
  task settle;
    repeat (6) @(posedge clk);
  endtask
  task lim(input [11:0] l, input a);
    begin
      chk("limit", l, limit);
      chk("active", a, active);
    end
  endtask
  task done(input [8*8-1:0] name);
    $display("test %0s finished", name);
  endtask
  task tally_and_finish;
    begin
      $display("comparisons %0d mismatches %0d", compares, fails);
      if (fails == 0 && compares > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    fails = fails + 1;
    tally_and_finish;
  end
  initial begin
    fails = 0;
    compares = 0;
    {rst_n, rd_en, wr_en, rev, regen, run_cmd, running} = 7'h00;
    {sw1, sw2, gate, flux, board} = 5'h00;
    addr = 8'h00;
    wdata = 32'h0000_0000;
    analog = 10'h000;
    {opt1, opt2, demand} = 36'h0_0000_0000;
    est = 16'h0000;
    quad[0] = 2'h0;
    quad[1] = 2'h3;
    quad[2] = 2'h2;
    quad[3] = 2'h1;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    bus(1'b0, 8'h00, 32'h0000_0000);
    chk("ctrl", 32'h0000_0003, rdata);
    bus(1'b0, 8'h04, 32'h0000_0000);
    chk("limits", 32'hB4B4_B4B4, rdata);
    bus(1'b1, 8'h40, 32'hFFFF_FFFF);
    bus(1'b0, 8'h40, 32'h0000_0000);
    chk("unmapped", 32'h0000_0000, rdata);
    lim(12'h708, 1'h1);
    done("reset");
    bus(1'b1, 8'h04, 32'h281E_140A);
    bus(1'b1, 8'h08, 32'h3728_2A29);
    gate <= 1'b1;
    // Switches and quadrant disagree, so the wrong source shows up
    for (k = 0; k < 2; k = k + 1) begin
      bus(1'b1, 8'h00, {21'h00_0000, k[2:0], 8'h03});
      for (i = 0; i < 4; i = i + 1) begin
        {sw2, sw1} <= i[1:0] ^ {~k[0], 1'b0};
        {rev, regen} <= quad[i[1:0] ^ {k[0], 1'b0}];
        settle;
        lim(12'h064 * (i + 1), 1'h1);
      end
    end
    gate <= 1'b0;
    settle;
    lim(12'h7D0, 1'h0);
    gate <= 1'b1;
    done("select");
    bus(1'b1, 8'h00, 32'h0000_0203);
    analog <= 10'h3FF;
    settle;
    lim(12'h7D0, 1'h1);
    analog <= 10'h200;
    settle;
    lim(12'h3E8, 1'h1);
    bus(1'b1, 8'h00, 32'h0000_0303);
    settle;
    lim(12'h7D0, 1'h0);
    board <= 1'b1;
    opt1 <= 12'h1F4;
    opt2 <= 12'h258;
    settle;
    lim(12'h1F4, 1'h1);
    bus(1'b1, 8'h00, 32'h0000_0403);
    settle;
    lim(12'h258, 1'h1);
    opt2 <= 12'hFFF;
    settle;
    lim(12'h7D0, 1'h1);
    bus(1'b1, 8'h00, 32'h0000_0503);
    settle;
    lim(12'h7D0, 1'h0);
    done("sources");
    // Limiting only under vector curves 3 to 5; overload restriction stays with the drive
    {rev, regen} <= 2'h0;
    for (i = 0; i < 7; i = i + 1) begin
      bus(1'b1, 8'h00, {24'h00_0000, i[7:0]});
      settle;
      k = (i >= 3 && i <= 5);
      lim(k ? 12'h064 : 12'h7D0, k[0]);
      chk("monitor", k[0], mon_ok);
    end
    bus(1'b1, 8'h00, 32'h0000_2003);
    bus(1'b1, 8'h10, 32'h0000_000A);
    demand <= 12'h3E8;
    settle;
    chk("flag", 5'h01, term_out);
    demand <= 12'h032;
    settle;
    chk("flag", 5'h00, term_out);
    done("curves");
    run_cmd <= 1'b1;
    settle;
    chk("run", 1'h0, run_ok);
    flux <= 1'b1;
    settle;
    chk("run", 1'h1, run_ok);
    chk("flux", 1'h1, prebuild);
    running <= 1'b1;
    flux <= 1'b0;
    settle;
    chk("freerun", 1'h1, free_run);
    flux <= 1'b1;
    k = 0;
    repeat (10) begin
      @(posedge clk);
      if (restart === 1'b1) begin
        k = k + 1;
        rdata[1:0] = rmode;
      end
    end
    chk("restarts", 32'h0000_0001, k);
    chk("rmode", 2'h2, rdata[1:0]);
    done("flux");
    bus(1'b1, 8'h18, 32'h000B_0B02);
    est <= 16'hFF9C;
    settle;
    chk("pulse", 16'h0064, pulse_val);
    chk("voltage", 16'hFF9C, volt_val);
    chk("current", 16'h0000, curr_val);
    done("meters");
    tally_and_finish;
  end
endmodule

bind tlsl_top tlsl_checker #(.N_OUT(N_OUT)) u_tlsl_checker (.i_clk(i_clk),
  .i_rst_n(i_rst_n), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
  .o_avs_waitrequest(o_avs_waitrequest), .o_torque_limit(o_torque_limit),
  .o_limit_active(o_limit_active), .o_term_out(o_term_out), .o_run_accept(o_run_accept),
  .o_free_run(o_free_run), .o_restart_req(o_restart_req), .o_monitor_valid(o_monitor_valid));
